//--- shared/swcmp_consts.svh
// Purpose: Offsets, field positions, reset values and codes of the
//          comparator threshold and interrupt-edge configuration block.
// Assumes: Registers are 24 bits wide and word addressed by offset.
// Notes:   Included by its bare name; definitions only.
//
// Function
// - Threshold codes 0..3 select 2V, 2.7V, 3V and 4V.
// - Threshold bits 11-10 set the threshold of inputs 20 to 23.
// - Threshold bits 9-8 set the threshold of inputs 16 to 19.
// - Threshold bits 7-6 set the threshold of inputs 12 to 15.
// - Threshold bits 5-4 set the threshold of inputs 8 to 11.
// - Threshold bits 3-2 set the threshold of inputs 4 to 7.
// - Threshold bits 1-0 set the threshold of inputs 0 to 3.
// - Threshold register sits at 21h and resets to zero.
// - Low edge register sits at 22h and resets to zero.
// - Edge code 0 gives no comparator interrupt for that input.
// - Edge code 1 flags a rise above the group threshold.
// - Edge code 2 flags a fall below the group threshold.
// - Edge code 3 flags both rising and falling crossings.
// - Inputs 8 to 11 use bits 17-16 to 23-22, group two threshold.
// - Input 7 uses bits 15-14 against the group one threshold.
// - Inputs 12 to 23 use the high edge register, input 23 at 23-22.
`ifndef SWCMP_CONSTS_SVH
`define SWCMP_CONSTS_SVH

`define SWC_ADDR_W 6
`define SWC_DATA_W 24
`define SWC_OFS_THR 6'h21
`define SWC_OFS_EDGE_LO 6'h22
`define SWC_OFS_EDGE_HI 6'h23
`define SWC_THR_W 12
`define SWC_THR_RST 12'h000
`define SWC_EDGE_RST 24'h000000
`define SWC_NUM_IN 24
`define SWC_NUM_GRP 6
`define SWC_MV_W 12
`define SWC_MV_CODE0 12'h7d0
`define SWC_MV_CODE1 12'ha8c
`define SWC_MV_CODE2 12'hbb8
`define SWC_MV_CODE3 12'hfa0
`define SWC_GRP0_POS 0
`define SWC_GRP1_POS 2
`define SWC_GRP2_POS 4
`define SWC_GRP3_POS 6
`define SWC_GRP4_POS 8
`define SWC_GRP5_POS 10

`endif

//--- shared/swcmp_pkg.sv
// Purpose: Types shared by the comparator configuration block.
// Assumes: Constants come from swcmp_consts.svh.
// Notes:   No process lives here.
`default_nettype none
package swcmp_pkg;
	// Interrupt-edge selection per input.
	typedef enum logic [1:0] {
		SWCMP_EDGE_OFF = 2'h0,
		SWCMP_EDGE_RISE = 2'h1,
		SWCMP_EDGE_FALL = 2'h2,
		SWCMP_EDGE_BOTH = 2'h3
	} swcmp_edge_t;
	// Comparator threshold code of one group.
	typedef logic [1:0] swcmp_thr_t;
endpackage
`default_nettype wire

//--- src/swcmp_cfg.sv
// Purpose: Threshold and interrupt-edge configuration of the switch
//          comparator path, with per-input crossing detection.
// Assumes: Comparator results arrive as one bit per input, qualified by a
//          one-cycle sample strobe, already compared at the group level.
// Notes:   Every output comes straight from a flip-flop.
`timescale 1ns/10ps
`default_nettype none
`include "swcmp_consts.svh"
module swcmp_cfg (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [`SWC_ADDR_W-1:0] reg_addr,
	input wire logic [`SWC_DATA_W-1:0] reg_wdata,
	output logic [`SWC_DATA_W-1:0] reg_rdata_ff,
	output logic reg_rd_valid_ff,
	input wire logic cmp_valid,
	input wire logic [`SWC_NUM_IN-1:0] cmp_above,
	output logic [`SWC_NUM_GRP*`SWC_MV_W-1:0] grp_thr_mv_ff,
	output logic [2*`SWC_NUM_IN-1:0] in_thr_code_ff,
	output logic [`SWC_NUM_IN-1:0] cmp_event_ff
);

	// ====================================================================
	// Declarations
	logic [`SWC_THR_W-1:0] thr_ff;
	logic [`SWC_DATA_W-1:0] edge_lo_ff;
	logic [`SWC_DATA_W-1:0] edge_hi_ff;
	logic [`SWC_NUM_IN-1:0] prev_ff;
	logic prev_valid_ff;
	logic [2*`SWC_NUM_IN-1:0] edge_all;
	logic [`SWC_NUM_IN-1:0] nxt_event;
	logic [2*`SWC_NUM_IN-1:0] nxt_in_thr;
	logic [`SWC_NUM_GRP*`SWC_MV_W-1:0] nxt_grp_mv;
	logic [`SWC_DATA_W-1:0] nxt_rdata;
	logic wr_thr;
	logic wr_lo;
	logic wr_hi;

	// Threshold code to millivolt value for the comparator reference.
	function automatic logic [`SWC_MV_W-1:0] thr_mv(
		input swcmp_pkg::swcmp_thr_t code
	);
		logic [`SWC_MV_W-1:0] mv;
		case (code)
			2'h0: mv = `SWC_MV_CODE0;
			2'h1: mv = `SWC_MV_CODE1;
			2'h2: mv = `SWC_MV_CODE2;
			default: mv = `SWC_MV_CODE3;
		endcase
		return mv;
	endfunction

	// ====================================================================
	// Register port
	// Write strobes decoded once so each register block stays simple.
	assign wr_thr = reg_wr_en && (reg_addr == `SWC_OFS_THR);
	assign wr_lo = reg_wr_en && (reg_addr == `SWC_OFS_EDGE_LO);
	assign wr_hi = reg_wr_en && (reg_addr == `SWC_OFS_EDGE_HI);

	// Threshold register; only the twelve field bits are stored, so the
	// reserved upper bits can never hold a written value.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			thr_ff <= `SWC_THR_RST;
		end else if (wr_thr) begin
			thr_ff <= reg_wdata[`SWC_THR_W-1:0];
		end
	end

	// Low interrupt-edge register for inputs zero to eleven.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			edge_lo_ff <= `SWC_EDGE_RST;
		end else if (wr_lo) begin
			edge_lo_ff <= reg_wdata;
		end
	end

	// High interrupt-edge register for inputs twelve to twenty-three.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			edge_hi_ff <= `SWC_EDGE_RST;
		end else if (wr_hi) begin
			edge_hi_ff <= reg_wdata;
		end
	end

	// Read mux; unmapped offsets answer zero rather than stale data.
	always_comb begin
		nxt_rdata = '0;
		case (reg_addr)
			`SWC_OFS_THR: begin
				nxt_rdata = {12'h000, thr_ff};
			end
			`SWC_OFS_EDGE_LO: begin
				nxt_rdata = edge_lo_ff;
			end
			`SWC_OFS_EDGE_HI: begin
				nxt_rdata = edge_hi_ff;
			end
			default: begin
				nxt_rdata = '0;
			end
		endcase
	end

	// Read data is captured on the strobe and held until the next read.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata_ff <= '0;
		end else if (reg_rd_en) begin
			reg_rdata_ff <= nxt_rdata;
		end
	end

	// One-cycle marker that read data is fresh.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			reg_rd_valid_ff <= 1'b0;
		end else begin
			reg_rd_valid_ff <= reg_rd_en;
		end
	end

	// ====================================================================
	// Group thresholds
	// Each group field drives its own reference value.
	always_comb begin
		nxt_grp_mv = '0;
		nxt_grp_mv[0*`SWC_MV_W +: `SWC_MV_W] =
			thr_mv(thr_ff[`SWC_GRP0_POS +: 2]);
		nxt_grp_mv[1*`SWC_MV_W +: `SWC_MV_W] =
			thr_mv(thr_ff[`SWC_GRP1_POS +: 2]);
		nxt_grp_mv[2*`SWC_MV_W +: `SWC_MV_W] =
			thr_mv(thr_ff[`SWC_GRP2_POS +: 2]);
		nxt_grp_mv[3*`SWC_MV_W +: `SWC_MV_W] =
			thr_mv(thr_ff[`SWC_GRP3_POS +: 2]);
		nxt_grp_mv[4*`SWC_MV_W +: `SWC_MV_W] =
			thr_mv(thr_ff[`SWC_GRP4_POS +: 2]);
		nxt_grp_mv[5*`SWC_MV_W +: `SWC_MV_W] =
			thr_mv(thr_ff[`SWC_GRP5_POS +: 2]);
	end

	// Registered so the analog reference sees a glitch-free value.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			grp_thr_mv_ff <= {`SWC_NUM_GRP{`SWC_MV_CODE0}};
		end else begin
			grp_thr_mv_ff <= nxt_grp_mv;
		end
	end

	// ====================================================================
	// Per-input edge selection and crossing detection
	// Both edge registers seen as one field array, input n at bits 2n+1:2n.
	assign edge_all = {edge_hi_ff, edge_lo_ff};

	genvar gi;
	generate
		for (gi = 0; gi < `SWC_NUM_IN; gi = gi + 1) begin : g_in
			swcmp_pkg::swcmp_edge_t mode;
			logic rise;
			logic fall;
			assign mode = swcmp_pkg::swcmp_edge_t'(edge_all[2*gi +: 2]);
			// Input gi belongs to group gi/4 and follows that threshold.
			assign nxt_in_thr[2*gi +: 2] =
				thr_ff[2*(gi/4) +: 2];
			// A crossing is a change between two successive samples.
			assign rise = cmp_above[gi] && !prev_ff[gi];
			assign fall = !cmp_above[gi] && prev_ff[gi];
			always_comb begin
				nxt_event[gi] = 1'b0;
				if (cmp_valid && prev_valid_ff) begin
					case (mode)
						swcmp_pkg::SWCMP_EDGE_OFF: begin
							nxt_event[gi] = 1'b0;
						end
						swcmp_pkg::SWCMP_EDGE_RISE: begin
							nxt_event[gi] = rise;
						end
						swcmp_pkg::SWCMP_EDGE_FALL: begin
							nxt_event[gi] = fall;
						end
						default: begin
							nxt_event[gi] = rise || fall;
						end
					endcase
				end
			end
		end
	endgenerate

	// Previous sample per input; only updated on a sample strobe.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			prev_ff <= '0;
		end else if (cmp_valid) begin
			prev_ff <= cmp_above;
		end
	end

	// The first sample after reset only sets the reference, because no
	// earlier level exists to call a crossing against.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			prev_valid_ff <= 1'b0;
		end else if (cmp_valid) begin
			prev_valid_ff <= 1'b1;
		end
	end

	// Event pulses and per-input threshold codes.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cmp_event_ff <= '0;
			in_thr_code_ff <= '0;
		end else begin
			cmp_event_ff <= nxt_event;
			in_thr_code_ff <= nxt_in_thr;
		end
	end

	// ====================================================================
	// Assertions
	property p_code_mv;
		@(posedge clock) disable iff (!arst_n)
		(thr_ff[1:0] == 2'h1) |=> (grp_thr_mv_ff[11:0] == 12'ha8c);
	endproperty
	a_code_mv: assert property (p_code_mv)
		else $error("Code 1 did not give 2.7V.");

	property p_grp5;
		@(posedge clock) disable iff (!arst_n)
		(wr_thr && reg_wdata[11:10] == 2'h3) |=> ##1
		(grp_thr_mv_ff[71:60] == 12'hfa0);
	endproperty
	a_grp5: assert property (p_grp5)
		else $error("Group five threshold not taken from bits 11-10.");

	property p_grp0;
		@(posedge clock) disable iff (!arst_n)
		(wr_thr && reg_wdata[1:0] == 2'h2) |=> ##1
		(grp_thr_mv_ff[11:0] == 12'hbb8);
	endproperty
	a_grp0: assert property (p_grp0)
		else $error("Group zero threshold not taken from bits 1-0.");

	// Middle groups, each watched at a code that a normal setup writes.
	property p_grp1;
		@(posedge clock) disable iff (!arst_n)
		(thr_ff[3:2] == 2'h2) |=> (grp_thr_mv_ff[23:12] == 12'hbb8);
	endproperty
	a_grp1: assert property (p_grp1)
		else $error("Group one threshold not taken from bits 3-2.");

	property p_grp2;
		@(posedge clock) disable iff (!arst_n)
		(thr_ff[5:4] == 2'h3) |=> (grp_thr_mv_ff[35:24] == 12'hfa0);
	endproperty
	a_grp2: assert property (p_grp2)
		else $error("Group two threshold not taken from bits 5-4.");

	property p_grp3;
		@(posedge clock) disable iff (!arst_n)
		(thr_ff[7:6] == 2'h1) |=> (grp_thr_mv_ff[47:36] == 12'ha8c);
	endproperty
	a_grp3: assert property (p_grp3)
		else $error("Group three threshold not taken from bits 7-6.");

	property p_grp4;
		@(posedge clock) disable iff (!arst_n)
		(thr_ff[9:8] == 2'h0) |=> (grp_thr_mv_ff[59:48] == 12'h7d0);
	endproperty
	a_grp4: assert property (p_grp4)
		else $error("Group four threshold not taken from bits 9-8.");

	property p_thr_read;
		@(posedge clock) disable iff (!arst_n)
		(reg_rd_en && reg_addr == `SWC_OFS_THR) |=>
		(reg_rd_valid_ff && reg_rdata_ff[23:12] == 12'h000 &&
		reg_rdata_ff[11:0] == $past(thr_ff));
	endproperty
	a_thr_read: assert property (p_thr_read)
		else $error("Threshold read wrong or reserved bits set.");

	property p_lo_rw;
		@(posedge clock) disable iff (!arst_n)
		(wr_lo && !reg_rd_en) ##1 (!reg_wr_en && !reg_rd_en) ##1
		(reg_rd_en && !reg_wr_en && reg_addr == `SWC_OFS_EDGE_LO) |=>
		(reg_rdata_ff == $past(reg_wdata, 3));
	endproperty
	a_lo_rw: assert property (p_lo_rw)
		else $error("Low edge register did not read back.");

	property p_off;
		@(posedge clock) disable iff (!arst_n)
		(edge_all[1:0] == 2'h0) |=> !cmp_event_ff[0];
	endproperty
	a_off: assert property (p_off)
		else $error("Event raised with edge code 0.");

	property p_rise;
		@(posedge clock) disable iff (!arst_n)
		(cmp_valid && prev_valid_ff && edge_all[1:0] == 2'h1 &&
		cmp_above[0] && !prev_ff[0]) |=> cmp_event_ff[0];
	endproperty
	a_rise: assert property (p_rise)
		else $error("Rising crossing on input 0 missed.");

	property p_fall;
		@(posedge clock) disable iff (!arst_n)
		(cmp_valid && prev_valid_ff && edge_lo_ff[15:14] == 2'h2 &&
		!cmp_above[7] && prev_ff[7]) |=> cmp_event_ff[7];
	endproperty
	a_fall: assert property (p_fall)
		else $error("Falling crossing on input 7 missed.");

	property p_both;
		@(posedge clock) disable iff (!arst_n)
		(cmp_valid && prev_valid_ff && edge_hi_ff[23:22] == 2'h3 &&
		cmp_above[23] != prev_ff[23]) |=> cmp_event_ff[23];
	endproperty
	a_both: assert property (p_both)
		else $error("Crossing on input 23 missed with code 3.");

	property p_in8_thr;
		@(posedge clock) disable iff (!arst_n)
		##1 (in_thr_code_ff[17:16] == $past(thr_ff[5:4]));
	endproperty
	a_in8_thr: assert property (p_in8_thr)
		else $error("Input 8 does not follow group two threshold.");

	property p_no_change;
		@(posedge clock) disable iff (!arst_n)
		(cmp_valid && cmp_above == prev_ff) |=> (cmp_event_ff == '0);
	endproperty
	a_no_change: assert property (p_no_change)
		else $error("Event without a change of sample.");

	c_rise: cover property (@(posedge clock) disable iff (!arst_n)
		cmp_event_ff[0]);
	c_both23: cover property (@(posedge clock) disable iff (!arst_n)
		cmp_event_ff[23]);
	c_fall7: cover property (@(posedge clock) disable iff (!arst_n)
		cmp_event_ff[7]);
	c_thr4v: cover property (@(posedge clock) disable iff (!arst_n)
		grp_thr_mv_ff[71:60] == 12'hfa0);

endmodule
`default_nettype wire

//--- sim/swcmp_host.sv
// Purpose: Host controller model for the comparator configuration registers.
// Assumes: Strobe port of swcmp_cfg; one access per task call.
// Notes:   Released address and data show the inverse of their last value.
`timescale 1ns/10ps
`default_nettype none
`include "swcmp_consts.svh"
module swcmp_host (
	input wire logic clock,
	output logic reg_wr_en,
	output logic reg_rd_en,
	output logic [`SWC_ADDR_W-1:0] reg_addr,
	output logic [`SWC_DATA_W-1:0] reg_wdata,
	input wire logic [`SWC_DATA_W-1:0] reg_rdata_ff,
	input wire logic reg_rd_valid_ff
);
	// ==================================================================
	// Idle bus.
	initial begin
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
	end

	// ==================================================================
	// Accesses.
	// A write holds its strobe for exactly one edge, then scrambles the bus.
	task automatic wr(input logic [`SWC_ADDR_W-1:0] a,
		input logic [`SWC_DATA_W-1:0] d);
		@(posedge clock);
		reg_wr_en <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr_en <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask

	// Valid is looked at on falling edges so the sample never races it.
	task automatic rd(input logic [`SWC_ADDR_W-1:0] a,
		output logic [`SWC_DATA_W-1:0] d, output logic ok);
		int n;
		@(posedge clock);
		reg_rd_en <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd_en <= 1'b0;
		reg_addr <= ~a;
		ok = 1'b0;
		d = 'x;
		for (n = 0; n < 4 && !ok; n++) begin
			@(negedge clock);
			if (reg_rd_valid_ff === 1'b1) begin
				ok = 1'b1;
				d = reg_rdata_ff;
			end
		end
	endtask
endmodule
`default_nettype wire

//--- sim/tb_switch_comparator_irq_config.sv
// Purpose: Self-checking bench for the comparator configuration block.
// Assumes: Host model drives the register port; bench drives samples.
// Notes:   Expected values come from the field layout, not the design.
`timescale 1ns/10ps
`default_nettype none
`include "swcmp_consts.svh"
module tb_switch_comparator_irq_config;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic reg_wr_en, reg_rd_en, reg_rd_valid_ff, cmp_valid = 1'b0;
	logic [`SWC_ADDR_W-1:0] reg_addr;
	logic [23:0] reg_wdata, reg_rdata_ff, cmp_event_ff, cmp_above = '0;
	logic [71:0] grp_thr_mv_ff;
	logic [47:0] in_thr_code_ff;
	int mismatches = 0;
	int comparisons = 0;
	logic [11:0] mv_tab [4] = '{`SWC_MV_CODE0, `SWC_MV_CODE1,
		`SWC_MV_CODE2, `SWC_MV_CODE3};
	logic [23:0] thr_wr [5] = '{24'h000555, 24'h000aaa, 24'hfff000,
		24'hff0e4e, 24'h000fff};
	logic [47:0] edge_tab [2] = '{48'he4e4e4_393939, 48'h555555_aaaaa8};
	logic [23:0] smp_tab [4] = '{24'h000000, 24'hffffff, 24'ha5a5a5,
		24'h5a5a5a};

	// ==================================================================
	// Clock, instances and watchdog.
	always #25 clock = ~clock;

	swcmp_cfg i_swcmp_cfg (.clock(clock), .arst_n(arst_n),
		.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
		.reg_rd_valid_ff(reg_rd_valid_ff), .cmp_valid(cmp_valid),
		.cmp_above(cmp_above), .grp_thr_mv_ff(grp_thr_mv_ff),
		.in_thr_code_ff(in_thr_code_ff), .cmp_event_ff(cmp_event_ff));

	swcmp_host i_swcmp_host (.clock(clock), .reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata_ff(reg_rdata_ff), .reg_rd_valid_ff(reg_rd_valid_ff));

	// The whole run needs well under a thousand cycles.
	initial begin
		repeat (4000) @(posedge clock);
		mismatches++;
		end_sim();
	end

	// ==================================================================
	// Helpers.
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [71:0] exp,
		input logic [71:0] got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic rd_chk(input logic [`SWC_ADDR_W-1:0] a,
		input logic [23:0] exp);
		logic [23:0] d;
		logic ok;
		i_swcmp_host.rd(a, d, ok);
		chk("reg_rd_valid_ff", 72'h1, {71'h0, ok});
		chk("reg_rdata_ff", {48'h0, exp}, {48'h0, d});
	endtask

	// Each input must carry the code of its own group of four.
	task automatic thr_chk(input logic [23:0] v);
		int n;
		for (n = 0; n < 6; n++) begin
			chk("grp_thr_mv_ff", {60'h0, mv_tab[v[2*n+:2]]},
				{60'h0, grp_thr_mv_ff[12*n+:12]});
		end
		for (n = 0; n < 24; n++) begin
			chk("in_thr_code_ff", {70'h0, v[2*(n/4)+:2]},
				{70'h0, in_thr_code_ff[2*n+:2]});
		end
	endtask

	// Event is registered on the edge that takes the sample and checked at the next falling edge.
	task automatic smp(input logic [23:0] v, input logic [23:0] exp);
		@(posedge clock);
		cmp_valid <= 1'b1;
		cmp_above <= v;
		@(posedge clock);
		cmp_valid <= 1'b0;
		cmp_above <= ~v;
		@(negedge clock);
		chk("cmp_event_ff", {48'h0, exp}, {48'h0, cmp_event_ff});
	endtask

	function automatic logic [23:0] ev_exp(input logic [47:0] f,
		input logic [23:0] p, input logic [23:0] c);
		int n;
		for (n = 0; n < 24; n++) begin
			ev_exp[n] = (f[2*n] & ~p[n] & c[n]) | (f[2*n+1] & p[n] & ~c[n]);
		end
	endfunction

	// ==================================================================
	// Main sequence.
	initial begin
		logic [23:0] prev;
		logic [23:0] exp_ev;
		int i;
		int j;
		repeat (12) @(posedge clock);
		arst_n <= 1'b1;
		@(negedge clock);
		thr_chk(24'h0);
		rd_chk(`SWC_OFS_THR, 24'h0);
		rd_chk(`SWC_OFS_EDGE_LO, 24'h0);
		rd_chk(`SWC_OFS_EDGE_HI, 24'h0);
		for (i = 0; i < 5; i++) begin
			i_swcmp_host.wr(`SWC_OFS_THR, thr_wr[i]);
			rd_chk(`SWC_OFS_THR, {12'h0, thr_wr[i][11:0]});
			thr_chk(thr_wr[i]);
		end
		// An unmapped offset must swallow writes and read back zero.
		i_swcmp_host.wr(6'h3f, 24'hffffff);
		rd_chk(6'h3f, 24'h0);
		prev = 24'hffffff;
		for (j = 0; j < 2; j++) begin
			i_swcmp_host.wr(`SWC_OFS_EDGE_HI, edge_tab[j][47:24]);
			i_swcmp_host.wr(`SWC_OFS_EDGE_LO, edge_tab[j][23:0]);
			rd_chk(`SWC_OFS_EDGE_LO, edge_tab[j][23:0]);
			rd_chk(`SWC_OFS_EDGE_HI, edge_tab[j][47:24]);
			// The first sample only sets the reference; a repeat is no crossing.
			if (j == 0) begin
				smp(24'hffffff, 24'h0);
				smp(24'hffffff, 24'h0);
			end
			for (i = 0; i < 4; i++) begin
				exp_ev = ev_exp(edge_tab[j], prev, smp_tab[i]);
				smp(smp_tab[i], exp_ev);
				prev = smp_tab[i];
			end
		end
		end_sim();
	end
endmodule
`default_nettype wire
